//--- inc/tpsa_pkg.sv
// constants shared by the tristate pin sharer arbiter
package tpsa_pkg;

	// ******************************
	// sizes
	// ******************************
	localparam int NUM_MASTERS = 2; // masters attached by default
	localparam int ADDR_W_BUS = 24; // widest shared address
	localparam int DATA_W_BUS = 16; // widest shared data
	localparam int SIG_W_LIMIT = 1024; // widest logical tristate signal
	localparam int DEF_M_ADDR_W [NUM_MASTERS] = '{24, 20}; // per-master address widths
	localparam int DEF_M_DATA_W [NUM_MASTERS] = '{16, 8}; // per-master data widths

	// ******************************
	// reset values
	// ******************************
	localparam logic GRANT_RST = 1'h0; // every grant low after reset
	localparam logic BUS_CTRL_RST = 1'h0; // read, write, enable idle after reset

	// ******************************
	// check bounds
	// ******************************
	localparam int RR_BOUND = 300; // longest idle wait with a free bus, in cycles

endpackage

//--- core/tpsa_rr_pick.sv
// rotating priority picker for the pin sharer
`timescale 1ns/1ps
module tpsa_rr_pick #(
	parameter int NUM_M = tpsa_pkg::NUM_MASTERS
) (
	// requests and previous winner
	input wire logic [NUM_M-1:0] req,
	input wire logic [NUM_M-1:0] last,
	// one-hot winner, zero when nobody asks
	output logic [NUM_M-1:0] pick
);

	// ******************************
	// search starts just after last winner
	// ******************************
	always_comb begin
		int pos;
		int idx;
		logic found;
		pos = 0;
		idx = 0;
		found = 1'b0;
		pick = '0;
		// locate previous winner
		for (int j = 0; j < NUM_M; j++) begin
			if (last[j]) begin
				pos = j;
			end
		end
		// first requester after it wins, last winner comes last
		for (int k = 1; k <= NUM_M; k++) begin
			idx = (pos + k) % NUM_M;
			if (!found && req[idx]) begin
				pick[idx] = 1'b1;
				found = 1'b1;
			end
		end
	end

endmodule

//--- core/tpsa_pin_sharer.sv
// tristate pin sharer: arbitrates masters and merges their shared pins
//
// Notes on behaviour
// - each slave port has request and grant
// - pins grouped by role: out, in, outen
// - one slave port per master, private handshake
// - same-role signals merged onto one bus
// - narrow signals aligned at bit 0, zero-padded
// - unshared signals pass through one register stage
// - all ports share one clock domain
// - request with grant low asks now
// - request with grant high asks next cycle
// - grant follows request, drops one cycle later
// - ins flow to master, outs to slave
// - data valid on bus one cycle after granted cycle
`timescale 1ns/1ps
module tpsa_pin_sharer #(
	parameter int NUM_M = tpsa_pkg::NUM_MASTERS,
	parameter int AW = tpsa_pkg::ADDR_W_BUS,
	parameter int DW = tpsa_pkg::DATA_W_BUS,
	parameter int M_ADDR_W [NUM_M] = tpsa_pkg::DEF_M_ADDR_W,
	parameter int M_DATA_W [NUM_M] = tpsa_pkg::DEF_M_DATA_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// per-master handshake
	input wire logic [NUM_M-1:0] m_request,
	output logic [NUM_M-1:0] m_grant,
	// per-master shared pins, packed master 0 lowest
	input wire logic [NUM_M*AW-1:0] m_addr_out,
	input wire logic [NUM_M*DW-1:0] m_data_out,
	input wire logic [NUM_M-1:0] m_data_outen,
	input wire logic [NUM_M-1:0] m_read_out,
	input wire logic [NUM_M-1:0] m_write_out,
	output logic [NUM_M*DW-1:0] m_data_in,
	// per-master unshared pins
	input wire logic [NUM_M-1:0] m_chipselect_out,
	input wire logic [NUM_M-1:0] m_irq_out,
	// merged bus toward bridge
	output logic [AW-1:0] bus_addr_out,
	output logic [DW-1:0] bus_data_out,
	output logic bus_data_outen,
	output logic bus_read_out,
	output logic bus_write_out,
	input wire logic [DW-1:0] bus_data_in,
	// unshared pins toward bridge
	output logic [NUM_M-1:0] bus_chipselect_out,
	output logic [NUM_M-1:0] bus_irq_out
);

	// ******************************
	// elaboration checks
	// ******************************
	if (NUM_M < 2 || AW < 1 || DW < 1 || AW > tpsa_pkg::SIG_W_LIMIT || DW > tpsa_pkg::SIG_W_LIMIT) begin : g_bad_size
		$error("pin sharer sizes out of range");
	end
	for (genvar g = 0; g < NUM_M; g++) begin : g_chk
		if (M_ADDR_W[g] < 1 || M_ADDR_W[g] > AW || M_DATA_W[g] < 1 || M_DATA_W[g] > DW) begin : g_bad_w
			$error("master signal width exceeds bus width");
		end
	end

	// low bits set up to a master's width
	function automatic logic [tpsa_pkg::SIG_W_LIMIT-1:0] low_mask(input int w);
		logic [tpsa_pkg::SIG_W_LIMIT-1:0] m;
		m = '0;
		for (int b = 0; b < tpsa_pkg::SIG_W_LIMIT; b++) begin
			if (b < w) begin
				m[b] = 1'b1;
			end
		end
		return m;
	endfunction

	// ******************************
	// arbitration state
	// ******************************
	logic [NUM_M-1:0] grant_q; // current owner, one-hot or zero
	logic [NUM_M-1:0] grant_d;
	logic [NUM_M-1:0] last_q; // previous winner for rotation
	logic [NUM_M-1:0] last_d;
	logic [NUM_M-1:0] pick; // rotating-priority winner
	logic busy; // owner still asking for next cycle

	tpsa_rr_pick #(
		.NUM_M(NUM_M)
	) u_pick (
		.req(m_request),
		.last(last_q),
		.pick(pick)
	);

	// next owner: keep while requesting, else pick again
	always_comb begin
		busy = |(grant_q & m_request);
		grant_d = grant_q;
		last_d = last_q;
		if (!busy) begin
			// owner dropped request: grant falls at the next edge, next one may win at once
			grant_d = pick;
			if (|pick) begin
				last_d = pick;
			end
		end
	end

	// register arbitration state
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			grant_q <= {NUM_M{tpsa_pkg::GRANT_RST}};
			last_q <= {{(NUM_M-1){1'b0}}, 1'b1};
		end else begin
			grant_q <= grant_d;
			last_q <= last_d;
		end
	end

	assign m_grant = grant_q;

	// ******************************
	// merged bus and pass-through
	// ******************************
	logic [AW-1:0] addr_q; // merged address
	logic [AW-1:0] addr_d;
	logic [DW-1:0] dout_q; // merged write data
	logic [DW-1:0] dout_d;
	logic outen_q; // merged output enable
	logic outen_d;
	logic read_q; // merged read
	logic read_d;
	logic write_q; // merged write
	logic write_d;
	logic [NUM_M*DW-1:0] din_q; // read data fanned back to masters
	logic [NUM_M*DW-1:0] din_d;
	logic [NUM_M-1:0] cs_q; // unshared chip selects
	logic [NUM_M-1:0] irq_q; // unshared interrupts

	// route owner's outs onto bus, idle bus all zero
	always_comb begin
		addr_d = '0;
		dout_d = '0;
		outen_d = tpsa_pkg::BUS_CTRL_RST;
		read_d = tpsa_pkg::BUS_CTRL_RST;
		write_d = tpsa_pkg::BUS_CTRL_RST;
		din_d = '0;
		for (int i = 0; i < NUM_M; i++) begin
			// owner's signals, upper bits forced low
			if (grant_q[i]) begin
				addr_d = m_addr_out[i*AW +: AW] & AW'(low_mask(M_ADDR_W[i]));
				dout_d = m_data_out[i*DW +: DW] & DW'(low_mask(M_DATA_W[i]));
				outen_d = m_data_outen[i];
				read_d = m_read_out[i];
				write_d = m_write_out[i];
			end
			// input pins go to every master at its own width
			din_d[i*DW +: DW] = bus_data_in & DW'(low_mask(M_DATA_W[i]));
		end
	end

	// register bus outputs, same clock on every port
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			addr_q <= '0;
			dout_q <= '0;
			outen_q <= tpsa_pkg::BUS_CTRL_RST;
			read_q <= tpsa_pkg::BUS_CTRL_RST;
			write_q <= tpsa_pkg::BUS_CTRL_RST;
			din_q <= '0;
			cs_q <= '0;
			irq_q <= '0;
		end else begin
			addr_q <= addr_d;
			dout_q <= dout_d;
			outen_q <= outen_d;
			read_q <= read_d;
			write_q <= write_d;
			din_q <= din_d;
			cs_q <= m_chipselect_out;
			irq_q <= m_irq_out;
		end
	end

	assign bus_addr_out = addr_q;
	assign bus_data_out = dout_q;
	assign bus_data_outen = outen_q;
	assign bus_read_out = read_q;
	assign bus_write_out = write_q;
	assign m_data_in = din_q;
	assign bus_chipselect_out = cs_q;
	assign bus_irq_out = irq_q;

	// ******************************
	// assertions
	// ******************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_single_owner: assert property ($onehot0(grant_q))
		else $error("more than one master granted");

	a_idle_quiet: assert property (grant_q == '0 |=> !bus_data_outen && !bus_read_out && !bus_write_out)
		else $error("bus active with no owner");

	a_pass_cs: assert property (##1 bus_chipselect_out == $past(m_chipselect_out) && bus_irq_out == $past(m_irq_out))
		else $error("unshared pin not passed through");

	for (genvar i = 0; i < NUM_M; i++) begin : g_asrt
		localparam logic [AW-1:0] AMASK = AW'(low_mask(M_ADDR_W[i]));
		localparam logic [DW-1:0] DMASK = DW'(low_mask(M_DATA_W[i]));

		// owner's last cycle and the cycle after it
		sequence s_final;
			grant_q[i] && !m_request[i];
		endsequence
		sequence s_released;
			!grant_q[i];
		endsequence

		a_grant_cause: assert property ($rose(grant_q[i]) |-> $past(m_request[i]))
			else $error("grant raised without request");

		a_grant_hold: assert property (grant_q[i] && m_request[i] |=> grant_q[i])
			else $error("grant dropped while request held");

		a_grant_drop: assert property (s_final |=> s_released)
			else $error("grant not dropped one cycle after request");

		a_handover: assert property (s_final ##0 (|(m_request & ~grant_q)) |=> s_released ##0 $onehot(grant_q))
			else $error("waiting master not granted at release");

		a_addr_route: assert property (grant_q[i] |=> bus_addr_out == ($past(m_addr_out[i*AW +: AW]) & AMASK)
			&& bus_read_out == $past(m_read_out[i]))
			else $error("owner's signals not routed to bus");

		a_pad_zero: assert property (grant_q[i] |=> (bus_addr_out & ~AMASK) == '0 && (bus_data_out & ~DMASK) == '0)
			else $error("upper bus bits not zero for narrow owner");

		a_din_fan: assert property (##1 m_data_in[i*DW +: DW] == ($past(bus_data_in) & DMASK))
			else $error("input data not returned to master");

		a_no_starve: assert property (m_request[i] && grant_q == '0 |=> grant_q != '0)
			else $error("free bus not granted to a requester");
	end

endmodule

//--- sim/tpsa_master_model.sv
// partner model: one shared bus master on a slave port
`timescale 1ns/1ps
module tpsa_master_model #(
	parameter int AW = 24,
	parameter int DW = 16
) (
	// clock, reset, bench control
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic go,
	input wire logic [3:0] len,
	// handshake
	output logic request,
	input wire logic grant,
	// pins
	output logic [AW-1:0] addr,
	output logic [DW-1:0] data,
	output logic outen,
	output logic read,
	output logic write,
	output logic cs,
	output logic irq
);
	logic [3:0] cnt_q; // grant cycles left
	// ******************************
	// handshake and pin stimulus
	// ******************************
	always @(posedge mclk) begin
		if (!reset_n) begin
			{addr, data, outen, read, write, cs, irq, request} <= '0;
			cnt_q <= '0;
		end else begin
			// pins change every cycle so a stale owner shows on the bus
			{addr, data, outen, read, write, cs, irq} <= (AW+DW+5)'({$urandom, $urandom});
			if (!request) begin
				// may ask again right after the final cycle
				if (go) begin
					request <= 1'h1;
					cnt_q <= len;
				end
			end else if (grant) begin
				// owning: drop request for the final cycle
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q <= 4'h2) begin
					request <= 1'h0;
				end
			end
			// no grant yet: request holds
		end
	end
endmodule

//--- sim/tpsa_pin_sharer_tb.sv
// self-checking bench for the tristate pin sharer
`timescale 1ns/1ps
module tpsa_pin_sharer_tb;
	localparam int N = tpsa_pkg::NUM_MASTERS;
	localparam int AW = tpsa_pkg::ADDR_W_BUS;
	localparam int DW = tpsa_pkg::DATA_W_BUS;
	// ******************************
	// signals
	// ******************************
	logic mclk, reset_n, chk_on;
	logic [N-1:0] go; // bench asks master i for access
	logic [N*4-1:0] len; // access length per master
	logic [DW-1:0] bus_data_in;
	wire [N-1:0] m_request, m_grant, m_data_outen, m_read_out, m_write_out, m_chipselect_out, m_irq_out;
	wire [N*AW-1:0] m_addr_out;
	wire [N*DW-1:0] m_data_out, m_data_in;
	wire [AW-1:0] bus_addr_out;
	wire [DW-1:0] bus_data_out;
	wire bus_data_outen, bus_read_out, bus_write_out;
	wire [N-1:0] bus_chipselect_out, bus_irq_out;
	int fails, n_tests, last; // last winner in the model
	logic [N-1:0] e_gnt, e_cs, e_irq;
	logic [31:0] e_addr, e_data;
	logic [2:0] e_ctl;
	logic [N*DW-1:0] e_din;
	tpsa_pin_sharer DUT (.mclk, .reset_n, .m_request, .m_grant, .m_addr_out, .m_data_out,
		.m_data_outen, .m_read_out, .m_write_out, .m_data_in, .m_chipselect_out, .m_irq_out,
		.bus_addr_out, .bus_data_out, .bus_data_outen, .bus_read_out, .bus_write_out,
		.bus_data_in, .bus_chipselect_out, .bus_irq_out);
	for (genvar i = 0; i < N; i++) begin : g_m
		tpsa_master_model #(.AW(AW), .DW(DW)) u_m (.mclk, .reset_n, .go(go[i]), .len(len[i*4 +: 4]),
			.request(m_request[i]), .grant(m_grant[i]), .addr(m_addr_out[i*AW +: AW]),
			.data(m_data_out[i*DW +: DW]), .outen(m_data_outen[i]), .read(m_read_out[i]),
			.write(m_write_out[i]), .cs(m_chipselect_out[i]), .irq(m_irq_out[i]));
	end
	// ******************************
	// reference model, one step per edge
	// ******************************
	always @(posedge mclk) begin : ref_model
		int held;
		int win;
		int o;
		held = -1;
		win = -1;
		o = -1;
		e_din = '0;
		for (int i = 0; i < N; i++) begin
			if (e_gnt[i] && m_request[i]) held = i;
			if (e_gnt[i]) o = i;
			e_din[i*DW +: DW] = bus_data_in & DW'((1 << tpsa_pkg::DEF_M_DATA_W[i]) - 1);
		end
		e_addr = '0;
		e_data = '0;
		e_ctl = '0;
		if (o >= 0) begin
			e_addr = 32'(m_addr_out[o*AW +: AW]) & ((32'h1 << tpsa_pkg::DEF_M_ADDR_W[o]) - 32'h1);
			e_data = 32'(m_data_out[o*DW +: DW]) & ((32'h1 << tpsa_pkg::DEF_M_DATA_W[o]) - 32'h1);
			e_ctl = {m_data_outen[o], m_read_out[o], m_write_out[o]};
		end
		// search starts after the last winner
		if (held < 0) begin
			for (int k = 1; k <= N; k++) begin
				if (m_request[(last + k) % N] && win < 0) win = (last + k) % N;
			end
			e_gnt = '0;
			if (win >= 0) begin
				e_gnt[win] = 1'h1;
				last = win;
			end
		end
		e_cs = m_chipselect_out;
		e_irq = m_irq_out;
		if (!reset_n) begin
			{e_gnt, e_cs, e_irq, e_addr, e_data, e_ctl, e_din} = '0;
			last = 0;
		end
	end
	// ******************************
	// comparison
	// ******************************
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	always @(negedge mclk) begin
		if (chk_on) begin
			check("grant", 32'(m_grant), 32'(e_gnt));
			check("addr", 32'(bus_addr_out), e_addr);
			check("data", 32'(bus_data_out), e_data);
			check("ctl", 32'({bus_data_outen, bus_read_out, bus_write_out}), 32'(e_ctl));
			check("din", 32'(m_data_in), 32'(e_din));
			check("cs", 32'(bus_chipselect_out), 32'(e_cs));
			check("irq", 32'(bus_irq_out), 32'(e_irq));
		end
	end
	// ******************************
	// stimulus
	// ******************************
	always @(posedge mclk) begin
		bus_data_in <= reset_n ? DW'($urandom) : '0;
		for (int i = 0; i < N; i++) len[i*4 +: 4] <= 4'(2 + $urandom % 4);
	end
	task automatic run(string name, logic [N-1:0] mask, int cycles, bit rnd);
		repeat (cycles) begin
			@(posedge mclk);
			go <= rnd ? N'($urandom) & mask : mask;
		end
		@(posedge mclk);
		go <= '0;
		repeat (14) @(posedge mclk);
		$display("test %s done", name);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (3000) @(posedge mclk);
		fails++;
		finish_test();
	end
	initial begin
		{reset_n, chk_on, go} = '0;
		void'($urandom(32'haf3b063b));
		repeat (12) @(posedge mclk);
		reset_n <= 1'h1;
		chk_on <= 1'h1;
		run("single master 0", 2'h1, 1, 0);
		run("single master 1", 2'h2, 1, 0);
		run("contention", 2'h3, 60, 0);
		run("random traffic", 2'h3, 300, 1);
		// reset in mid-traffic
		go <= 2'h3;
		repeat (7) @(posedge mclk);
		reset_n <= 1'h0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'h1;
		run("mid reset", 2'h3, 20, 1);
		finish_test();
	end
endmodule
